// [common/bus_exc_defs.vh]
// Constants for the bus exception and status unit.
// Assumes inclusion by bare name from design files.
`ifndef BUS_EXC_DEFS_VH
`define BUS_EXC_DEFS_VH
`define QS_DISCARD4 2'h0
`define QS_DISCARD1 2'h1
`define QS_DISCARD2 2'h2
`define QS_NONE 2'h3
`define RST_ACCEPT_CYCLES 2'h2
`define STOP_BUDGET 2'h2
`define ADDR_W 32
`define SIZE_W 3
`define STAT_W 4
`define MODE_W 2
`endif

// [logic/sync2.v]
// Two-flop synchroniser for one asynchronous level.
// Assumes the input comes from outside the clk domain.
`default_nettype none
module sync2 (
  input wire clk,
  input wire rst_n,
  input wire async_in,
  input wire rst_val,
  output reg sync_out
);
  reg meta_r;
  // ==========================================
  // Sync chain; first flop feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [logic/bus_exception_unit.v]
// Bus exception and status unit of a 32-bit processor bus interface.
// Assumes clk is fast enough to sample both quadrature input clocks,
// and that bus cycle and decode logic live outside.
`default_nettype none
`include "bus_exc_defs.vh"

// Notes on behaviour
// - Restart request accepted only after two consecutive asserted samples.
// - Accepted restart drives reset acknowledge immediately, ignoring bus activity.
// - Restart routine begins only after reset acknowledge is released.
// - Retry ends current transaction; same one reruns after retry drops.
// - Relinquish request ends transaction and floats listed bus outputs.
// - Relinquish ack asserted only once all listed outputs are floated.
// - Relinquish ack is the answer to relinquish-and-retry.
// - Relinquish ack open-drain; released when preempted transaction reruns.
// - Arbitration inputs ignored while relinquish request is asserted.
// - Other master uses bus while floated; rerun after request drops.
// - Stop input blocks starting new instructions once the first instruction after stop completes.
// - At most one more instruction completes after stop before halting.
// - Float-all input puts every output pin in high impedance.
// - Queue status code: 00 four, 01 one, 10 two, 11 none.
// - Instruction start flag marks opcode fetch from internal queue.
// - Falling edge of lagging clock starts each machine cycle.
module bus_exception_unit (
  input wire clk,
  input wire rst_n,
  input wire lagging_clock,
  input wire leading_clock,
  input wire restart_request_in,
  input wire retry_in,
  input wire relinquish_request_in,
  input wire stop_in,
  input wire float_all_outputs_in,
  input wire bus_request_in,
  input wire restart_routine_done,
  input wire xact_req,
  input wire xact_done,
  input wire [`ADDR_W-1:0] core_address,
  input wire [`SIZE_W-1:0] core_size,
  input wire [`STAT_W-1:0] core_status,
  input wire [`MODE_W-1:0] core_mode,
  input wire core_vaddr,
  input wire core_abort,
  input wire core_data_ready,
  input wire opcode_take,
  input wire instr_done,
  input wire [1:0] core_queue_code,
  output wire bus_request_seen,
  output reg restart_ack_out,
  output reg restart_routine_go,
  output reg xact_rerun,
  output wire instr_start_allowed,
  output reg halted,
  output reg machine_cycle_start,
  output reg [`ADDR_W-1:0] address_lines,
  output wire address_lines_oe_n,
  output reg addr_strobe,
  output wire addr_strobe_oe_n,
  output reg data_strobe,
  output wire data_strobe_oe_n,
  output reg [`SIZE_W-1:0] transfer_size,
  output wire transfer_size_oe_n,
  output reg [`STAT_W-1:0] access_status,
  output wire access_status_oe_n,
  output reg cycle_initiate,
  output wire cycle_initiate_oe_n,
  output reg virtual_addr_flag,
  output wire virtual_addr_flag_oe_n,
  output reg data_ready_out,
  output wire data_ready_out_oe_n,
  output reg abort_out,
  output wire abort_out_oe_n,
  output reg [`MODE_W-1:0] transfer_mode_bits,
  output wire transfer_mode_bits_oe_n,
  output wire relinquish_ack_out,
  output wire relinquish_ack_out_oe_n,
  output reg [1:0] queue_status_code,
  output wire queue_status_code_oe_n,
  output reg instruction_start_flag,
  output wire instruction_start_flag_oe_n,
  output wire restart_ack_oe_n
);
  // ==========================================
  // Input synchronisers
  wire rst_req_s, retry_s, rreq_s, stop_s, float_s, lag_s, lead_s, busrq_s;
  sync2 u_s_rst (.clk(clk), .rst_n(rst_n), .async_in(restart_request_in), .rst_val(1'b0), .sync_out(rst_req_s));
  sync2 u_s_rty (.clk(clk), .rst_n(rst_n), .async_in(retry_in), .rst_val(1'b0), .sync_out(retry_s));
  sync2 u_s_rrq (.clk(clk), .rst_n(rst_n), .async_in(relinquish_request_in), .rst_val(1'b0), .sync_out(rreq_s));
  sync2 u_s_stp (.clk(clk), .rst_n(rst_n), .async_in(stop_in), .rst_val(1'b0), .sync_out(stop_s));
  sync2 u_s_flt (.clk(clk), .rst_n(rst_n), .async_in(float_all_outputs_in), .rst_val(1'b0), .sync_out(float_s));
  sync2 u_s_lag (.clk(clk), .rst_n(rst_n), .async_in(lagging_clock), .rst_val(1'b0), .sync_out(lag_s));
  sync2 u_s_led (.clk(clk), .rst_n(rst_n), .async_in(leading_clock), .rst_val(1'b0), .sync_out(lead_s));
  sync2 u_s_brq (.clk(clk), .rst_n(rst_n), .async_in(bus_request_in), .rst_val(1'b0), .sync_out(busrq_s));

  // ==========================================
  // Machine cycle marker
  reg lag_d_r, lead_d_r;
  wire cyc = lag_d_r & ~lag_s;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lag_d_r <= 1'b0;
      lead_d_r <= 1'b0;
      machine_cycle_start <= 1'b0;
    end else begin
      lag_d_r <= lag_s;
      lead_d_r <= lead_s; // Kept for phase reference only
      machine_cycle_start <= cyc;
    end
  end

  // Arbitration request ignored during preemption
  assign bus_request_seen = busrq_s & ~rreq_s;

  // ==========================================
  // Restart request filter: counts asserted samples per machine cycle
  reg [1:0] rst_cnt_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= 2'h0;
      restart_ack_out <= 1'b0;
      restart_routine_go <= 1'b0;
    end else begin
      restart_routine_go <= 1'b0;
      if (!rst_req_s) begin
        rst_cnt_r <= 2'h0;
      end else if (cyc && rst_cnt_r != `RST_ACCEPT_CYCLES) begin
        rst_cnt_r <= rst_cnt_r + 2'h1;
      end
      if (rst_req_s && rst_cnt_r == `RST_ACCEPT_CYCLES) begin
        restart_ack_out <= 1'b1; // Immediate, bus state ignored
      end else if (restart_ack_out && restart_routine_done && !rst_req_s) begin
        restart_ack_out <= 1'b0;
        restart_routine_go <= 1'b1; // Routine starts after release
      end
    end
  end

  // ==========================================
  // Bus exception state machine
  localparam ST_IDLE = 5'h01;
  localparam ST_BUSY = 5'h02;
  localparam ST_RETRY = 5'h04;
  localparam ST_FLOAT = 5'h08;
  localparam ST_RERUN = 5'h10;
  reg [4:0] state_r, state_nxt;
  reg rr_float_r, rack_r;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rreq_s) state_nxt = ST_FLOAT;
        else if (xact_req) state_nxt = ST_BUSY;
      end
      ST_BUSY: begin
        if (rreq_s) state_nxt = ST_FLOAT;
        else if (retry_s) state_nxt = ST_RETRY;
        else if (xact_done) state_nxt = ST_IDLE;
      end
      ST_RETRY: begin
        // Preemption outranks a pending retry
        if (rreq_s) state_nxt = ST_FLOAT;
        else if (!retry_s) state_nxt = ST_RERUN;
      end
      ST_FLOAT: begin
        if (!rreq_s) state_nxt = ST_RERUN;
      end
      ST_RERUN: state_nxt = ST_BUSY;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Floating lags the request by one cycle; ack follows the float
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      rr_float_r <= 1'b0;
      rack_r <= 1'b0;
      xact_rerun <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rr_float_r <= (state_nxt == ST_FLOAT);
      rack_r <= rr_float_r && (state_nxt == ST_FLOAT);
      xact_rerun <= (state_nxt == ST_RERUN);
    end
  end

  // ==========================================
  // Bus output registers and enables (low enable drives)
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      address_lines <= {`ADDR_W{1'b0}};
      addr_strobe <= 1'b1;
      data_strobe <= 1'b1;
      transfer_size <= {`SIZE_W{1'b0}};
      access_status <= {`STAT_W{1'b0}};
      cycle_initiate <= 1'b1;
      virtual_addr_flag <= 1'b1;
      data_ready_out <= 1'b1;
      abort_out <= 1'b1;
      transfer_mode_bits <= {`MODE_W{1'b0}};
    end else begin
      address_lines <= core_address;
      addr_strobe <= ~(state_r == ST_BUSY);
      data_strobe <= ~(state_r == ST_BUSY);
      transfer_size <= core_size;
      access_status <= core_status;
      cycle_initiate <= ~(state_nxt == ST_BUSY && state_r != ST_BUSY);
      virtual_addr_flag <= ~core_vaddr;
      data_ready_out <= ~core_data_ready;
      abort_out <= ~core_abort;
      transfer_mode_bits <= core_mode;
    end
  end
  wire bus_oe_n = rr_float_r | float_s;
  assign address_lines_oe_n = bus_oe_n;
  assign addr_strobe_oe_n = bus_oe_n;
  assign data_strobe_oe_n = bus_oe_n;
  assign transfer_size_oe_n = bus_oe_n;
  assign access_status_oe_n = bus_oe_n;
  assign cycle_initiate_oe_n = bus_oe_n;
  assign virtual_addr_flag_oe_n = bus_oe_n;
  assign data_ready_out_oe_n = bus_oe_n;
  assign abort_out_oe_n = bus_oe_n;
  assign transfer_mode_bits_oe_n = bus_oe_n;
  // Open drain: only ever drives low, pull-up restores high
  assign relinquish_ack_out = 1'b0;
  assign relinquish_ack_out_oe_n = ~rack_r | float_s;
  assign queue_status_code_oe_n = float_s;
  assign instruction_start_flag_oe_n = float_s;
  assign restart_ack_oe_n = float_s;

  // ==========================================
  // Stop handling: the current instruction and one more may finish after stop
  reg [1:0] stop_left_r;
  reg stopping_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stopping_r <= 1'b0;
      stop_left_r <= 2'h0;
      halted <= 1'b0;
    end else if (!stop_s) begin
      stopping_r <= 1'b0;
      halted <= 1'b0;
    end else if (!stopping_r) begin
      stopping_r <= 1'b1;
      stop_left_r <= `STOP_BUDGET; // Current one plus one more
    end else if (instr_done && stop_left_r != 2'h0) begin
      stop_left_r <= stop_left_r - 2'h1;
      if (stop_left_r == 2'h1) halted <= 1'b1;
    end
  end
  // Blocks new starts once the first instruction of the budget completes
  assign instr_start_allowed = ~halted & ~restart_ack_out &
                               ~(stop_s & stopping_r & stop_left_r != `STOP_BUDGET);

  // ==========================================
  // Queue status and start flag, registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_status_code <= `QS_NONE;
      instruction_start_flag <= 1'b0;
    end else if (restart_ack_out || halted) begin
      queue_status_code <= `QS_NONE;
      instruction_start_flag <= 1'b0;
    end else begin
      queue_status_code <= core_queue_code;
      instruction_start_flag <= opcode_take & instr_start_allowed;
    end
  end
endmodule
`default_nettype wire

// [tb/bus_exc_chk.sv]
// Port-level timing checks for the bus exception unit.
// Assumes it is bound into bus_exception_unit and reads only its ports.
`default_nettype none
module bus_exc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lagging_clock,
  input wire logic restart_request_in,
  input wire logic relinquish_request_in,
  input wire logic float_all_outputs_in,
  input wire logic bus_request_seen,
  input wire logic restart_ack_out,
  input wire logic restart_routine_go,
  input wire logic halted,
  input wire logic machine_cycle_start,
  input wire logic address_lines_oe_n,
  input wire logic data_strobe_oe_n,
  input wire logic relinquish_ack_out_oe_n,
  input wire logic [1:0] queue_status_code,
  input wire logic queue_status_code_oe_n,
  input wire logic instruction_start_flag,
  input wire logic restart_ack_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Restart and status
  // Antecedents wait a cycle so register skew between outputs is tolerated
  a_quiet_when_stopped: assert property (
    (restart_ack_out && $past(restart_ack_out)) || (halted && $past(halted)) |->
    queue_status_code == 2'h3 && !instruction_start_flag) else $error("queue active while stopped");
  a_ack_needs_req: assert property (
    $rose(restart_ack_out) |-> $past(restart_request_in, 6) && $past(restart_request_in, 9))
    else $error("restart ack without a held request");
  a_go_after_ack: assert property (
    restart_routine_go |-> !restart_ack_out) else $error("restart routine started under ack");
  a_float_every: assert property (
    float_all_outputs_in [*3] |=> queue_status_code_oe_n && restart_ack_oe_n && address_lines_oe_n)
    else $error("output still driven under float");
  // ==========================================
  // Relinquish handshake and machine cycles
  a_ack_floated: assert property (
    !relinquish_ack_out_oe_n |-> address_lines_oe_n && data_strobe_oe_n) else $error("ack before float");
  a_ack_in_time: assert property (
    (relinquish_request_in && !float_all_outputs_in) [*7] |-> !relinquish_ack_out_oe_n)
    else $error("relinquish ack late");
  a_ack_released: assert property (
    !relinquish_request_in [*5] |-> relinquish_ack_out_oe_n) else $error("relinquish ack held");
  a_arb_ignored: assert property (
    relinquish_request_in [*3] |-> !bus_request_seen) else $error("bus request seen in relinquish");
  a_cycle_start: assert property (
    $fell(lagging_clock) && $past(rst_n, 3) |-> ##[1:4] machine_cycle_start)
    else $error("machine cycle start missing");
  c_restart: cover property ($rose(restart_ack_out));
  c_relinquish: cover property ($fell(relinquish_ack_out_oe_n));
  c_halt: cover property ($rose(halted));
endmodule
bind bus_exception_unit bus_exc_chk i_chk (.clk, .rst_n, .lagging_clock, .restart_request_in,
  .relinquish_request_in, .float_all_outputs_in, .bus_request_seen, .restart_ack_out, .restart_routine_go,
  .halted, .machine_cycle_start, .address_lines_oe_n, .data_strobe_oe_n, .relinquish_ack_out_oe_n,
  .queue_status_code, .queue_status_code_oe_n, .instruction_start_flag, .restart_ack_oe_n);
`default_nettype wire

// [tb/quad_clk_src.sv]
// Model of the external clock source: two clocks of one frequency.
// Assumes the unit samples both through its own synchronisers.
`default_nettype none
module quad_clk_src #(parameter int QUARTER = 200) (
  output logic leading_clock,
  output logic lagging_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // Odd start offset keeps edges away from the system clock edges
  initial begin
    leading_clock = 1'h1;
    lagging_clock = 1'h1;
    #37;
    forever begin
      #QUARTER leading_clock = 1'h0;
      #QUARTER lagging_clock = 1'h0;
      #QUARTER leading_clock = 1'h1;
      #QUARTER lagging_clock = 1'h1;
    end
  end
endmodule
`default_nettype wire

// [tb/test_bus_exception_unit.sv]
// Self-checking bench for the bus exception unit.
// Assumes the unit, its checker and the clock source model compile first.
`default_nettype none
module test_bus_exception_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, restart_request_in = 1'h0, retry_in = 1'h0, stop_in = 1'h0;
  logic relinquish_request_in = 1'h0, float_all_outputs_in = 1'h0, bus_request_in = 1'h0;
  logic restart_routine_done = 1'h0, xact_req = 1'h0, xact_done = 1'h0, opcode_take = 1'h0, instr_done = 1'h0;
  logic [1:0] core_queue_code = 2'h3;
  logic [31:0] core_val = 32'h12345678;
  wire leading_clock, lagging_clock, bus_request_seen, restart_ack_out, restart_routine_go, xact_rerun;
  wire instr_start_allowed, halted, machine_cycle_start, address_lines_oe_n, data_strobe_oe_n;
  wire relinquish_ack_out_oe_n, queue_status_code_oe_n, instruction_start_flag, instruction_start_flag_oe_n;
  wire restart_ack_oe_n, relinquish_ack_out, addr_strobe, cycle_initiate;
  // Far-side pull-up on the open-drain relinquish ack line
  wire rrack_pin = relinquish_ack_out_oe_n ? 1'h1 : relinquish_ack_out;
  wire [1:0] queue_status_code;
  wire [5:0] watch;
  int mismatches = 0, checked = 0, cyc = 0, n, mc;
  // Signals that scenarios wait on, picked by bit index
  assign watch = {instruction_start_flag, halted, relinquish_ack_out_oe_n, xact_rerun, restart_routine_go,
    restart_ack_out};
  quad_clk_src i_clk_src (.leading_clock, .lagging_clock);
  bus_exception_unit i_dut (.clk, .rst_n, .lagging_clock, .leading_clock, .restart_request_in, .retry_in,
    .relinquish_request_in, .stop_in, .float_all_outputs_in, .bus_request_in, .restart_routine_done,
    .xact_req, .xact_done, .core_address(core_val), .core_size(core_val[2:0]), .core_status(core_val[3:0]),
    .core_mode(core_val[1:0]), .core_vaddr(core_val[0]), .core_abort(core_val[1]),
    .core_data_ready(core_val[2]), .opcode_take, .instr_done, .core_queue_code, .bus_request_seen,
    .restart_ack_out, .restart_routine_go, .xact_rerun, .instr_start_allowed, .halted, .machine_cycle_start,
    .address_lines(), .address_lines_oe_n, .addr_strobe, .addr_strobe_oe_n(), .data_strobe(),
    .data_strobe_oe_n, .transfer_size(), .transfer_size_oe_n(), .access_status(), .access_status_oe_n(),
    .cycle_initiate, .cycle_initiate_oe_n(), .virtual_addr_flag(), .virtual_addr_flag_oe_n(),
    .data_ready_out(), .data_ready_out_oe_n(), .abort_out(), .abort_out_oe_n(), .transfer_mode_bits(),
    .transfer_mode_bits_oe_n(), .relinquish_ack_out, .relinquish_ack_out_oe_n, .queue_status_code,
    .queue_status_code_oe_n, .instruction_start_flag, .instruction_start_flag_oe_n, .restart_ack_oe_n);
  // ==========================================
  // Clock, hang guard and shared helpers
  always #50 clk = ~clk;
  // Run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move 5 ns after the edge, outputs are read there too
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task automatic wait_for(input int b, input logic v);
    n = 0;
    while (watch[b] !== v && n < 60) begin
      step(1);
      n++;
    end
    chk(watch[b], v);
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_queue;
    chk(instr_start_allowed, 1'h1);
    for (int q = 0; q < 4; q++) begin
      core_queue_code = q[1:0];
      step(3);
      chk(queue_status_code, q);
    end
    opcode_take = 1'h1;
    step(1);
    chk(instruction_start_flag, 1'h1);
    opcode_take = 1'h0;
    step(1);
    chk(instruction_start_flag, 1'h0);
    $display("queue test over");
  endtask
  task automatic t_restart;
    restart_request_in = 1'h1;
    step(1);
    restart_request_in = 1'h0;
    step(30);
    chk(restart_ack_out, 1'h0);
    restart_request_in = 1'h1;
    wait_for(0, 1'h1);
    core_queue_code = 2'h0;
    opcode_take = 1'h1;
    step(2);
    chk({queue_status_code, instruction_start_flag}, 3'h6);
    core_queue_code = 2'h3;
    opcode_take = 1'h0;
    restart_request_in = 1'h0;
    restart_routine_done = 1'h1;
    wait_for(1, 1'h1);
    chk(restart_ack_out, 1'h0);
    restart_routine_done = 1'h0;
    $display("restart test over");
  endtask
  task automatic t_relinquish;
    xact_req = 1'h1;
    step(1);
    xact_req = 1'h0;
    bus_request_in = 1'h1;
    relinquish_request_in = 1'h1;
    wait_for(3, 1'h0);
    chk({address_lines_oe_n, data_strobe_oe_n, bus_request_seen, rrack_pin}, 4'hC);
    step(4);
    chk({relinquish_ack_out_oe_n, bus_request_seen}, 2'h0);
    relinquish_request_in = 1'h0;
    wait_for(2, 1'h1);
    step(1);
    chk({relinquish_ack_out_oe_n, address_lines_oe_n, rrack_pin}, 3'h5);
    bus_request_in = 1'h0;
    xact_done = 1'h1;
    step(1);
    xact_done = 1'h0;
    $display("relinquish test over");
  endtask
  task automatic t_retry;
    xact_req = 1'h1;
    step(1);
    xact_req = 1'h0;
    retry_in = 1'h1;
    step(6);
    chk({xact_rerun, addr_strobe}, 2'h1);
    retry_in = 1'h0;
    wait_for(2, 1'h1);
    step(1);
    chk(cycle_initiate, 1'h0);
    xact_done = 1'h1;
    step(1);
    xact_done = 1'h0;
    $display("retry test over");
  endtask
  task automatic t_stop;
    stop_in = 1'h1;
    step(4);
    instr_done = 1'h1;
    step(1);
    instr_done = 1'h0;
    step(2);
    chk(halted, 1'h0);
    instr_done = 1'h1;
    step(1);
    instr_done = 1'h0;
    wait_for(4, 1'h1);
    chk(instr_start_allowed, 1'h0);
    core_queue_code = 2'h2;
    opcode_take = 1'h1;
    step(1);
    chk({queue_status_code, instruction_start_flag}, 3'h6);
    stop_in = 1'h0;
    wait_for(4, 1'h0);
    core_queue_code = 2'h3;
    opcode_take = 1'h0;
    $display("stop test over");
  endtask
  task automatic t_float_and_cycles;
    float_all_outputs_in = 1'h1;
    step(4);
    chk({queue_status_code_oe_n, instruction_start_flag_oe_n, restart_ack_oe_n, address_lines_oe_n}, 4'hF);
    float_all_outputs_in = 1'h0;
    step(4);
    chk(queue_status_code_oe_n, 1'h0);
    mc = 0;
    repeat (80) begin
      step(1);
      mc += int'(machine_cycle_start === 1'h1);
    end
    chk(mc, 10);
    $display("float and cycle test over");
  endtask
  // Main sequence: reset for 12 cycles, then every scenario in turn
  initial begin
    step(12);
    rst_n = 1'h1;
    step(2);
    t_queue;
    t_restart;
    t_relinquish;
    t_retry;
    t_stop;
    t_float_and_cycles;
    report_and_stop;
  end
endmodule
`default_nettype wire
